// ==== rtl/tdc_core.sv ====
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module tdc_core #(
  parameter bit THREE_WINDING = 1'b1 // 0 builds the two_winding_variant
) (
  input wire logic clk_sys, // 40 MHz system clock
  input wire logic sys_rst, // async reset, active high
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [tdc_pkg::ADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic sample_valid, // one simultaneous sample set
  input wire tdc_pkg::tdc_samples_t samples, // all winding phase samples
  output logic [tdc_pkg::NPH-1:0] trip_phase, // per-phase differential trip
  output tdc_pkg::tdc_status_t status, // latched decision flags
  output logic decision_valid // pulse when status updates
);
  localparam int NPH = tdc_pkg::NPH;
  localparam int NW = tdc_pkg::NWIND;
  localparam int AW = tdc_pkg::ACC_W;
  localparam int RW = AW + 2;
  localparam int LW = RW + tdc_pkg::SLOPE_W;
  localparam int PW = AW + tdc_pkg::PCT_W;

  logic [31:0] ctrl;
  logic [31:0] diff_min;
  logic [31:0] slope;
  logic [31:0] h2_pct;
  logic [31:0] h5_pct;
  logic [31:0] hs_level;
  logic [tdc_pkg::CODE_W-1:0] code;
  logic code_ok;
  logic prot_en;

  tdc_pkg::tdc_shift3_t sh [NW];
  tdc_pkg::tdc_shift3_t shd [NW];
  logic sh_valid;
  logic signed [tdc_pkg::DIFF_W-1:0] diff [NPH];
  logic signed [tdc_pkg::DIFF_W-1:0] next_diff [NPH];
  logic diff_valid;
  logic [tdc_pkg::IDX_W-1:0] idx;

  logic [AW-1:0] dmag1 [NPH];
  logic [AW-1:0] dmag2 [NPH];
  logic [AW-1:0] dmag5 [NPH];
  logic [AW-1:0] wmag [NPH][NW];
  logic [NPH-1:0] done;
  logic [RW-1:0] restr [NPH];
  logic [LW-1:0] limit [NPH];
  logic [NPH-1:0] over;
  logic [NPH-1:0] blk2;
  logic [NPH-1:0] blk5;
  logic [NPH-1:0] hs;
  logic [NPH-1:0] next_trip;

  logic acc_wr;
  logic addr_ok;
  logic wr_ok;
  logic [31:0] rd_mux;

  assign code = ctrl[tdc_pkg::CTRL_CODE_LSB +: tdc_pkg::CODE_W];
  assign code_ok = (code == tdc_pkg::CODE_DELTA_STAR_LAG30) ||
                   (code == tdc_pkg::CODE_DELTA_STAR_LAG150);
  assign prot_en = ctrl[tdc_pkg::CTRL_EN];

  // compensation stage, one set taken per strobe
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sh <= '{default: '0};
      sh_valid <= 1'b0;
    end else begin
      sh_valid <= sample_valid;
      if (sample_valid) begin
        sh[0] <= tdc_pkg::tdc_identity(samples.prim);
        sh[1] <= tdc_pkg::tdc_compensate(samples.sec, code);
        // tertiary is star-connected against the delta primary
        sh[2] <= THREE_WINDING ? tdc_pkg::tdc_compensate(samples.ter, code) : '0;
      end
    end
  end

  always_comb begin
    for (int p = 0; p < NPH; p++) begin
      next_diff[p] = tdc_pkg::DIFF_W'($signed(sh[0][p])) + tdc_pkg::DIFF_W'($signed(sh[1][p]))
                   + tdc_pkg::DIFF_W'($signed(sh[2][p]));
    end
  end

  // shd keeps winding samples aligned with diff when strobes come back to back
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      diff <= '{default: '0};
      shd <= '{default: '0};
      diff_valid <= 1'b0;
    end else begin
      diff_valid <= sh_valid;
      if (sh_valid) begin
        diff <= next_diff;
        shd <= sh;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      idx <= '0;
    end else if (diff_valid) begin
      idx <= idx + 1'b1;
    end
  end

  for (genvar p = 0; p < NPH; p++) begin : g_ph
    tdc_dft #(.HARM(tdc_pkg::HARM_FUND), .IN_W(tdc_pkg::DIFF_W)) u_fund (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .en(diff_valid),
      .idx(idx),
      .x(diff[p]),
      .mag(dmag1[p]),
      .done(done[p])
    );
    tdc_dft #(.HARM(tdc_pkg::HARM_2ND), .IN_W(tdc_pkg::DIFF_W)) u_h2 (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .en(diff_valid),
      .idx(idx),
      .x(diff[p]),
      .mag(dmag2[p]),
      .done()
    );
    tdc_dft #(.HARM(tdc_pkg::HARM_5TH), .IN_W(tdc_pkg::DIFF_W)) u_h5 (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .en(diff_valid),
      .idx(idx),
      .x(diff[p]),
      .mag(dmag5[p]),
      .done()
    );
    for (genvar w = 0; w < NW; w++) begin : g_w
      if (w < 2 || THREE_WINDING) begin : g_on
        tdc_dft #(.HARM(tdc_pkg::HARM_FUND), .IN_W(tdc_pkg::SHIFT_W)) u_wind (
          .clk_sys(clk_sys),
          .sys_rst(sys_rst),
          .en(diff_valid),
          .idx(idx),
          .x($signed(shd[w][p])),
          .mag(wmag[p][w]),
          .done()
        );
      end else begin : g_off
        assign wmag[p][w] = '0;
      end
    end
  end

  // restraint is half the summed through-currents
  always_comb begin
    for (int p = 0; p < NPH; p++) begin
      restr[p] = (RW'(wmag[p][0]) + RW'(wmag[p][1]) + RW'(wmag[p][2])) >> 1;
      limit[p] = LW'(diff_min) + ((LW'(slope[tdc_pkg::SLOPE_W-1:0]) * LW'(restr[p]))
                 >> tdc_pkg::SLOPE_SHIFT);
      over[p] = LW'(dmag1[p]) > limit[p];
      blk2[p] = PW'(dmag2[p]) * PW'(tdc_pkg::PCT_FULL) >
                PW'(h2_pct[tdc_pkg::PCT_W-1:0]) * PW'(dmag1[p]);
      blk5[p] = PW'(dmag5[p]) * PW'(tdc_pkg::PCT_FULL) >
                PW'(h5_pct[tdc_pkg::PCT_W-1:0]) * PW'(dmag1[p]);
      hs[p] = dmag1[p] > hs_level;
      // unknown codes compensate nothing, so they must not trip
      next_trip[p] = prot_en && code_ok && ((over[p] && !blk2[p] && !blk5[p]) || hs[p]);
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      status <= '0;
      trip_phase <= '0;
      decision_valid <= 1'b0;
    end else begin
      decision_valid <= done[0];
      if (done[0]) begin
        status <= '{code_err: !code_ok, over: over, blk5: blk5, blk2: blk2, hs: hs,
                    trip: next_trip};
        trip_phase <= next_trip;
      end
    end
  end

  // apb slave, zero wait states
  assign pready = 1'b1;
  assign acc_wr = psel && penable && pwrite && wr_ok;

  always_comb begin
    wr_ok = 1'b1;
    addr_ok = 1'b1;
    rd_mux = '0;
    case (paddr)
      tdc_pkg::A_CTRL: rd_mux = ctrl;
      tdc_pkg::A_DIFF_MIN: rd_mux = diff_min;
      tdc_pkg::A_SLOPE: rd_mux = slope;
      tdc_pkg::A_H2_PCT: rd_mux = h2_pct;
      tdc_pkg::A_H5_PCT: rd_mux = h5_pct;
      tdc_pkg::A_HS_LEVEL: rd_mux = hs_level;
      tdc_pkg::A_STATUS: begin
        rd_mux = 32'(status);
        wr_ok = 1'b0;
      end
      tdc_pkg::A_DMAG0: begin
        rd_mux = dmag1[0];
        wr_ok = 1'b0;
      end
      tdc_pkg::A_DMAG1: begin
        rd_mux = dmag1[1];
        wr_ok = 1'b0;
      end
      tdc_pkg::A_DMAG2: begin
        rd_mux = dmag1[2];
        wr_ok = 1'b0;
      end
      default: begin
        addr_ok = 1'b0;
        wr_ok = 1'b0;
      end
    endcase
  end

  assign pslverr = psel && penable && (!addr_ok || (pwrite && !wr_ok));

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl <= tdc_pkg::CTRL_RST;
      diff_min <= tdc_pkg::DIFF_MIN_RST;
      slope <= tdc_pkg::SLOPE_RST;
      h2_pct <= tdc_pkg::H2_PCT_RST;
      h5_pct <= tdc_pkg::H5_PCT_RST;
      hs_level <= tdc_pkg::HS_LEVEL_RST;
    end else if (acc_wr) begin
      case (paddr)
        tdc_pkg::A_CTRL: ctrl <= pwdata;
        tdc_pkg::A_DIFF_MIN: diff_min <= pwdata;
        tdc_pkg::A_SLOPE: slope <= pwdata;
        tdc_pkg::A_H2_PCT: h2_pct <= pwdata;
        tdc_pkg::A_H5_PCT: h5_pct <= pwdata;
        tdc_pkg::A_HS_LEVEL: hs_level <= pwdata;
        default: ;
      endcase
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_shift;
    sh_valid ##1 diff_valid;
  endsequence

  a_primary_identity: assert property (sample_valid |=>
    sh[0][0] == tdc_pkg::SHIFT_W'($signed($past(samples.prim[0]))))
    else $error("primary phase a not passed unchanged");

  a_lag30_map: assert property (
    sample_valid && code == tdc_pkg::CODE_DELTA_STAR_LAG30 |=>
    sh[1][0] == tdc_pkg::tdc_sdiff($past(samples.sec[0]), $past(samples.sec[1])) &&
    sh[1][2] == tdc_pkg::tdc_sdiff($past(samples.sec[2]), $past(samples.sec[0])))
    else $error("lag30 secondary mapping wrong");

  a_lag150_map: assert property (
    sample_valid && code == tdc_pkg::CODE_DELTA_STAR_LAG150 |=>
    sh[1][0] == tdc_pkg::tdc_sdiff($past(samples.sec[2]), $past(samples.sec[0])) &&
    sh[1][1] == tdc_pkg::tdc_sdiff($past(samples.sec[0]), $past(samples.sec[1])))
    else $error("lag150 secondary mapping wrong");

  a_zero_seq: assert property (
    sample_valid && code_ok && samples.sec[0] == samples.sec[1] &&
    samples.sec[1] == samples.sec[2] |=> sh[1] == '0)
    else $error("zero sequence reached shifted secondary");

  a_tertiary_path: assert property (
    sample_valid && samples.ter == samples.sec |=> sh[2] == (THREE_WINDING ? sh[1] : '0))
    else $error("tertiary compensation mismatch");

  a_set_flow: assert property (sample_valid |=> s_shift)
    else $error("sample set not carried through");

  a_diff_sum: assert property (s_shift |->
    diff[1] == tdc_pkg::DIFF_W'($signed($past(sh[0][1]))) +
    tdc_pkg::DIFF_W'($signed($past(sh[1][1]))) + tdc_pkg::DIFF_W'($signed($past(sh[2][1]))))
    else $error("differential current is not the winding sum");

  a_window_end: assert property (
    diff_valid && idx == tdc_pkg::IDX_W'(tdc_pkg::NSAMP - 1) |=> done[0] ##1 decision_valid)
    else $error("decision did not follow the last slot");

  a_trip_gate: assert property (
    decision_valid && trip_phase[0] && !status.hs[0] |->
    status.over[0] && !status.blk2[0] && !status.blk5[0])
    else $error("restrained phase tripped");

  a_hs_bypass: assert property (
    decision_valid && status.hs[0] && prot_en && !status.code_err |-> trip_phase[0])
    else $error("high-speed check did not bypass restraint");

  a_inrush_block: assert property (
    decision_valid && status.blk2[0] && !status.hs[0] |-> !trip_phase[0])
    else $error("second harmonic did not block");

  a_overexc_block: assert property (
    decision_valid && status.blk5[0] && !status.hs[0] |-> !trip_phase[0])
    else $error("fifth harmonic did not block");
endmodule
`default_nettype wire

// ==== rtl/tdc_pkg.sv ====
package tdc_pkg;
  // How it works
  // - connection code picks the compensation matrices
  // - delta primary passes through unchanged
  // - lag30 code: a-b, b-c, c-a over root3
  // - lag150 code: c-a, a-b, b-c over root3
  // - tertiary compensated like secondary, primary referenced
  // - two-winding variant drops all tertiary processing
  // - per-sample shifted currents and three differentials
  // - fundamental Fourier of each differential current
  // - second harmonic Fourier of each differential
  // - fifth harmonic Fourier of each differential
  // - strong second harmonic blocks differential operation
  // - strong fifth harmonic blocks differential operation
  // - magnitudes of shifted and differential currents
  // - per phase: differential above percentage characteristic
  // - restraint current from shifted phase magnitudes
  // - second and fifth to fundamental ratios restrain
  // - unrestrained high-speed differential overcurrent check
  // - star-side transform removes zero sequence
  localparam int SAMPLE_W = 16;
  localparam int SHIFT_W = 18;
  localparam int DIFF_W = 20;
  localparam int ACC_W = 32;
  localparam int NSAMP = 16;
  localparam int IDX_W = 4;
  localparam int NPH = 3;
  localparam int NWIND = 3;
  localparam int CODE_W = 4;
  localparam int SCALE_SHIFT = 15;
  localparam int SLOPE_W = 16;
  localparam int SLOPE_SHIFT = 8;
  localparam int PCT_W = 8;
  localparam int SIN_OFS = 12;
  localparam int HARM_FUND = 1;
  localparam int HARM_2ND = 2;
  localparam int HARM_5TH = 5;
  localparam logic [16:0] INV_SQRT3 = 17'h049e7;
  localparam logic [PCT_W-1:0] PCT_FULL = 8'h64;
  localparam logic [CODE_W-1:0] CODE_DELTA_STAR_LAG30 = 4'h0;
  localparam logic [CODE_W-1:0] CODE_DELTA_STAR_LAG150 = 4'h1;
  localparam logic signed [7:0] COS_TAB [NSAMP] = '{8'sh7f, 8'sh75, 8'sh5a, 8'sh31,
    8'sh00, -8'sh31, -8'sh5a, -8'sh75, -8'sh7f, -8'sh75, -8'sh5a, -8'sh31,
    8'sh00, 8'sh31, 8'sh5a, 8'sh75};
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] A_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] A_DIFF_MIN = 8'h04;
  localparam logic [ADDR_W-1:0] A_SLOPE = 8'h08;
  localparam logic [ADDR_W-1:0] A_H2_PCT = 8'h0c;
  localparam logic [ADDR_W-1:0] A_H5_PCT = 8'h10;
  localparam logic [ADDR_W-1:0] A_HS_LEVEL = 8'h14;
  localparam logic [ADDR_W-1:0] A_STATUS = 8'h18;
  localparam logic [ADDR_W-1:0] A_DMAG0 = 8'h1c;
  localparam logic [ADDR_W-1:0] A_DMAG1 = 8'h20;
  localparam logic [ADDR_W-1:0] A_DMAG2 = 8'h24;
  localparam int CTRL_EN = 0;
  localparam int CTRL_CODE_LSB = 4;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam logic [31:0] DIFF_MIN_RST = 32'h0000_4000;
  localparam logic [31:0] SLOPE_RST = 32'h0000_0040;
  localparam logic [31:0] H2_PCT_RST = 32'h0000_000f;
  localparam logic [31:0] H5_PCT_RST = 32'h0000_0019;
  localparam logic [31:0] HS_LEVEL_RST = 32'h0040_0000;

  typedef logic [NPH-1:0][SAMPLE_W-1:0] tdc_phase3_t;
  typedef logic [NPH-1:0][SHIFT_W-1:0] tdc_shift3_t;
  typedef struct packed {
    tdc_phase3_t prim;
    tdc_phase3_t sec;
    tdc_phase3_t ter;
  } tdc_samples_t;
  typedef struct packed {
    logic code_err;
    logic [NPH-1:0] over;
    logic [NPH-1:0] blk5;
    logic [NPH-1:0] blk2;
    logic [NPH-1:0] hs;
    logic [NPH-1:0] trip;
  } tdc_status_t;

  function automatic logic [SHIFT_W-1:0] tdc_sdiff(logic signed [SAMPLE_W-1:0] p,
                                                   logic signed [SAMPLE_W-1:0] q);
    logic signed [SAMPLE_W:0] d;
    logic signed [SAMPLE_W+17:0] m;
    d = (SAMPLE_W+1)'(p) - (SAMPLE_W+1)'(q);
    m = (SAMPLE_W+18)'(d) * (SAMPLE_W+18)'($signed(INV_SQRT3));
    return m[SCALE_SHIFT +: SHIFT_W];
  endfunction

  function automatic tdc_shift3_t tdc_identity(tdc_phase3_t x);
    tdc_shift3_t y;
    for (int i = 0; i < NPH; i++) begin
      y[i] = SHIFT_W'($signed(x[i]));
    end
    return y;
  endfunction

  function automatic tdc_shift3_t tdc_compensate(tdc_phase3_t x, logic [CODE_W-1:0] code);
    tdc_shift3_t y;
    y = '0;
    case (code)
      CODE_DELTA_STAR_LAG30: begin
        y[0] = tdc_sdiff(x[0], x[1]);
        y[1] = tdc_sdiff(x[1], x[2]);
        y[2] = tdc_sdiff(x[2], x[0]);
      end
      CODE_DELTA_STAR_LAG150: begin
        y[0] = tdc_sdiff(x[2], x[0]);
        y[1] = tdc_sdiff(x[0], x[1]);
        y[2] = tdc_sdiff(x[1], x[2]);
      end
      default: y = '0;
    endcase
    return y;
  endfunction
endpackage

// ==== rtl/tdc_dft.sv ====
`timescale 1ns/100ps
`default_nettype none
module tdc_dft #(
  parameter int HARM = 1,
  parameter int IN_W = 20
) (
  input wire logic clk_sys, // system clock
  input wire logic sys_rst, // async reset, active high
  input wire logic en, // one new sample
  input wire logic [tdc_pkg::IDX_W-1:0] idx, // slot within the cycle
  input wire logic signed [IN_W-1:0] x, // sample value
  output logic [tdc_pkg::ACC_W-1:0] mag, // magnitude of last full cycle
  output logic done // pulse after the last slot
);
  localparam int AW = tdc_pkg::ACC_W;
  logic [tdc_pkg::IDX_W-1:0] k_cos;
  logic [tdc_pkg::IDX_W-1:0] k_sin;
  logic signed [AW-1:0] re;
  logic signed [AW-1:0] im;
  logic signed [AW-1:0] next_re;
  logic signed [AW-1:0] next_im;
  logic [AW-1:0] abs_re;
  logic [AW-1:0] abs_im;

  always_comb begin
    k_cos = tdc_pkg::IDX_W'(int'(idx) * HARM);
    k_sin = k_cos + tdc_pkg::IDX_W'(tdc_pkg::SIN_OFS);
    next_re = (idx == '0 ? AW'(0) : re) + AW'(x) * AW'(tdc_pkg::COS_TAB[k_cos]);
    next_im = (idx == '0 ? AW'(0) : im) + AW'(x) * AW'(tdc_pkg::COS_TAB[k_sin]);
    abs_re = next_re[AW-1] ? AW'(-next_re) : AW'(next_re);
    abs_im = next_im[AW-1] ? AW'(-next_im) : AW'(next_im);
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      re <= '0;
      im <= '0;
    end else if (en) begin
      re <= next_re;
      im <= next_im;
    end
  end

  // max plus half min: cheap magnitude, within about 12 percent
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      mag <= '0;
      done <= 1'b0;
    end else begin
      done <= en && (idx == tdc_pkg::IDX_W'(tdc_pkg::NSAMP - 1));
      if (en && (idx == tdc_pkg::IDX_W'(tdc_pkg::NSAMP - 1))) begin
        mag <= (abs_re > abs_im) ? abs_re + (abs_im >> 1) : abs_im + (abs_re >> 1);
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/tdc_source.sv ====
`timescale 1ns/100ps
`default_nettype none
module tdc_source (
  input wire logic clk_sys, // system clock
  output logic sample_valid, // one simultaneous sample set
  output tdc_pkg::tdc_samples_t samples // all winding phase samples
);
  initial begin
    sample_valid = 1'b0;
    samples = '0;
  end
  // sixteen sets make one power cycle; one winding, one phase or all phases
  task automatic send_window(input int w, input int ph, input bit all, input int a1,
                             input int h, input int ah, input int gap);
    tdc_pkg::tdc_samples_t s;
    logic signed [15:0] v;
    for (int n = 0; n < tdc_pkg::NSAMP; n++) begin
      v = 16'(a1 * tdc_pkg::COS_TAB[n] + ah * tdc_pkg::COS_TAB[(n * h) % tdc_pkg::NSAMP]);
      s = '0;
      for (int p = 0; p < 3; p++) begin
        if (all || p == ph) begin
          if (w == 0) s.prim[p] = v;
          else if (w == 1) s.sec[p] = v;
          else s.ter[p] = v;
        end
      end
      samples <= s;
      sample_valid <= 1'b1;
      @(posedge clk_sys);
      if (gap > 0) begin
        // stale data between strobes must never be reused
        sample_valid <= 1'b0;
        samples <= ~s;
        repeat (gap) @(posedge clk_sys);
      end
    end
    sample_valid <= 1'b0;
    samples <= ~s;
  endtask
endmodule
`default_nettype wire

// ==== tb/tb_transformer_differential_core.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_transformer_differential_core;
  logic clk_sys;
  logic sys_rst;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sample_valid;
  tdc_pkg::tdc_samples_t samples;
  logic [2:0] trip_phase;
  logic [2:0] trip_2w;
  tdc_pkg::tdc_status_t status;
  tdc_pkg::tdc_status_t status_2w;
  logic decision_valid;
  logic dv_2w;
  int n_errors;
  int checks_done;
  int cycles;

  tdc_source src (.clk_sys(clk_sys), .sample_valid(sample_valid), .samples(samples));
  tdc_core #(.THREE_WINDING(1'b1)) DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sample_valid(sample_valid), .samples(samples),
    .trip_phase(trip_phase), .status(status), .decision_valid(decision_valid));
  // same bus and stream, so both builds see identical settings
  tdc_core #(.THREE_WINDING(1'b0)) dut_2w (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(),
    .pready(), .pslverr(), .sample_valid(sample_valid), .samples(samples),
    .trip_phase(trip_2w), .status(status_2w), .decision_valid(dv_2w));

  task automatic conclude();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge, so a following call never drives psel twice in one step
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic run(input int w, input int ph, input bit all, input int a1, input int h,
                     input int ah, input int gap);
    int k;
    src.send_window(w, ph, all, a1, h, ah, gap);
    k = 0;
    do begin
      @(negedge clk_sys);
      k++;
    end while (decision_valid !== 1'b1 && k < 40);
    check("two winding strobe", dv_2w, 32'h1);
    @(posedge clk_sys);
    check("decision latency", k, 4 - gap);
  endtask

  task automatic t_regs();
    logic [31:0] rv [6] = '{tdc_pkg::CTRL_RST, tdc_pkg::DIFF_MIN_RST, tdc_pkg::SLOPE_RST,
      tdc_pkg::H2_PCT_RST, tdc_pkg::H5_PCT_RST, tdc_pkg::HS_LEVEL_RST};
    logic [31:0] q;
    logic e;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0, q, e);
      check("reset value", q, rv[i]);
    end
    apb(1'b0, 8'h28, 32'h0, q, e);
    check("unmapped read", {q[30:0], e}, 32'h1);
    apb(1'b1, tdc_pkg::A_STATUS, 32'hffff_ffff, q, e);
    check("status write refused", e, 32'h1);
    apb(1'b0, tdc_pkg::A_STATUS, 32'h0, q, e);
    check("status idle", q, 32'h0);
  endtask

  task automatic t_codes();
    // sec phase b alone lands on two phases, which pair depends on the code
    logic [2:0] ex [2][4] = '{'{3'h2, 3'h3, 3'h3, 3'h0}, '{3'h2, 3'h6, 3'h6, 3'h0}};
    logic [31:0] q;
    logic e;
    wr(tdc_pkg::A_DIFF_MIN, 32'h0);
    wr(tdc_pkg::A_SLOPE, 32'h0);
    wr(tdc_pkg::A_HS_LEVEL, 32'hffff_ffff);
    wr(tdc_pkg::A_H2_PCT, 32'hff);
    wr(tdc_pkg::A_H5_PCT, 32'hff);
    for (int c = 0; c < 2; c++) begin
      wr(tdc_pkg::A_CTRL, 32'h1 | 32'(c << 4));
      for (int s = 0; s < 4; s++) begin
        run((s == 3) ? 1 : s, 1, s == 3, 64, 2, 0, s % 3);
        check("over", status.over, ex[c][s]);
        check("trip", trip_phase, ex[c][s]);
        check("two winding", status_2w.over, (s == 2) ? 3'h0 : ex[c][s]);
        check("two winding trip", trip_2w, (s == 2) ? 3'h0 : ex[c][s]);
        for (int p = 0; p < 3 && s == 3; p++) begin
          apb(1'b0, 8'(32'h1c + 4 * p), 32'h0, q, e);
          check("zero sequence magnitude", q, 32'h0);
        end
      end
    end
  endtask

  task automatic t_harm();
    int t [4][4] = '{'{8, 2, 64, 1}, '{8, 5, 64, 1}, '{64, 2, 0, 1}, '{8, 2, 64, 0}};
    logic [3:0] ex [4] = '{4'h8, 4'h4, 4'h1, 4'hb};
    wr(tdc_pkg::A_CTRL, 32'h1);
    wr(tdc_pkg::A_H2_PCT, tdc_pkg::H2_PCT_RST);
    wr(tdc_pkg::A_H5_PCT, tdc_pkg::H5_PCT_RST);
    for (int i = 0; i < 4; i++) begin
      wr(tdc_pkg::A_HS_LEVEL, (t[i][3] == 1) ? 32'hffff_ffff : 32'h0);
      run(0, 0, 1'b0, t[i][0], t[i][1], t[i][2], 0);
      check("blk2 blk5 hs trip",
            {status.blk2[0], status.blk5[0], status.hs[0], trip_phase[0]},
            ex[i]);
    end
  endtask

  task automatic t_bad();
    wr(tdc_pkg::A_HS_LEVEL, 32'hffff_ffff);
    wr(tdc_pkg::A_CTRL, 32'h21);
    run(0, 0, 1'b0, 64, 2, 0, 1);
    check("bad code", {status.code_err, trip_phase}, 32'h8);
    wr(tdc_pkg::A_CTRL, 32'h0);
    run(0, 0, 1'b0, 64, 2, 0, 2);
    check("disabled trip", trip_phase, 32'h0);
    // a steep slope lets the restraint hold off phases a and b, the two that carry current
    wr(tdc_pkg::A_CTRL, 32'h1);
    wr(tdc_pkg::A_SLOPE, 32'hffff);
    run(1, 1, 1'b0, 64, 2, 0, 0);
    check("restrained", {status.over, trip_phase}, 32'h0);
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      conclude();
    end
  end

  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    n_errors = 0;
    checks_done = 0;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    t_regs();
    t_codes();
    t_harm();
    t_bad();
    conclude();
  end
endmodule
`default_nettype wire
